// *** rtl/transport_stream_output_port.sv ***
// transport stream output formatter: bytes in, framed stream pins out
// assumes a byte source on mclk with valid/ready and an APB master on mclk
//
// Overview of operation
// [R1] Polarity of stream clock, marker, valid strobe and error flag is set.
// [R2] Outputs launch on the falling stream clock edge unless rising is set.
// [R3] Each packet carries exactly 188 data bytes.
// [R4] Data-only framings keep the valid strobe asserted all the time.
// [R5] An errored packet shows the error flag from its first unit to its last.
// [R6] Serial framings hold the marker for the eight bits of the first byte.
// [R7] Redundancy framings assert the strobe only over the 188 packet bytes.
// [R8] Parallel framings put one byte per stream clock on the 8-bit bus.
// [R9] Serial framings put one bit per stream clock on the serial output.
// [R10] Reset is active low, asynchronous, with a synchronised release.
// [R11] The reset source holds reset low 1 ms after supplies are stable.
// [R12] The reset source holds reset low 1 us after clocks are stable.
// [R13] The reference clock is 4 MHz or 25 MHz, 4 MHz from a clock source.
// [R14] Parallel framings hold the marker for one stream clock, first byte.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module transport_stream_output_port #(
  parameter int unsigned RED_BYTES = ts_out_pkg::RED_BYTES_DEFAULT
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic srcValid,
  input wire ts_out_pkg::src_t srcWord,
  output logic srcReady,
  output ts_out_pkg::pins_t tsOut
);

  logic rstMeta;
  logic rstn;
  ts_out_pkg::cfg_t cfg;
  logic [7:0] divReg;
  logic [15:0] pktCnt;
  ts_out_pkg::fmt_state_t state;
  logic sclk;
  logic [7:0] halfCnt;
  logic [7:0] byteCnt;
  logic [2:0] bitIdx;
  logic [11:0] redCnt;
  logic [7:0] shiftReg;
  logic markAct;
  logic errAct;
  logic tick;
  logic isLaunch;
  logic lastUnit;
  logic pktDone;
  logic redDone;
  logic wantFirst;
  logic wantNext;
  logic needByte;
  logic avail;
  logic stall;
  logic go;
  logic take;
  logic startPkt;
  logic nextByte;
  logic shiftBit;
  logic enterRed;
  logic inPkt;
  logic strobeAct;
  logic [11:0] redLast;
  logic [31:0] next_prdata;

  // reset release passes two flops so no flop leaves reset mid-cycle
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta <= 1'b0; // [R10]
      rstn <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstn <= rstMeta; // [R10]
    end
  end

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == ts_out_pkg::CTRL_OFS) || (a == ts_out_pkg::DIV_OFS) ||
             (a == ts_out_pkg::STAT_OFS) || (a == ts_out_pkg::PKTCNT_OFS);
  endfunction : mapped

  // configuration registers; change them only while disabled
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cfg <= ts_out_pkg::cfg_t'(ts_out_pkg::CTRL_RESET);
      divReg <= ts_out_pkg::DIV_RESET;
    end else if (psel && penable && pwrite) begin
      if (paddr == ts_out_pkg::CTRL_OFS) begin
        cfg <= ts_out_pkg::cfg_t'(pwdata[7:0]); // [R1] [R2]
      end
      if (paddr == ts_out_pkg::DIV_OFS) begin
        divReg <= pwdata[7:0];
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ts_out_pkg::CTRL_OFS: next_prdata[7:0] = cfg;
      ts_out_pkg::DIV_OFS: next_prdata[7:0] = divReg;
      ts_out_pkg::STAT_OFS: begin
        next_prdata[ts_out_pkg::STAT_BUSY_BIT] =
          (state != ts_out_pkg::ST_IDLE);
        next_prdata[ts_out_pkg::STAT_STALL_BIT] = stall;
        next_prdata[ts_out_pkg::STAT_RED_BIT] =
          (state == ts_out_pkg::ST_REDUND);
        next_prdata[ts_out_pkg::STAT_BYTE_LSB +: 8] = byteCnt;
      end
      ts_out_pkg::PKTCNT_OFS: next_prdata[15:0] = pktCnt;
      default: next_prdata = 32'h0000_0000;
    endcase
  end

  // read data captured in the setup cycle, held through the access cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);

  // launch decode; a missing byte freezes the stream clock before its edge
  assign tick = cfg.enable && (halfCnt >= divReg);
  assign isLaunch = tick && ((~(sclk ^ cfg.clkInv)) == cfg.launchRise); // [R2]
  assign inPkt = (state == ts_out_pkg::ST_PACKET);
  assign lastUnit = !cfg.serial || (bitIdx == ts_out_pkg::BIT_LAST);
  assign pktDone = inPkt && lastUnit &&
                   (byteCnt == ts_out_pkg::PKT_LAST); // [R3]
  assign redLast = cfg.serial ? 12'(RED_BYTES * ts_out_pkg::BITS_PER_BYTE - 1)
                              : 12'(RED_BYTES - 1);
  assign redDone = (state == ts_out_pkg::ST_REDUND) && (redCnt == redLast);
  assign wantFirst = (state == ts_out_pkg::ST_IDLE) ||
                     (pktDone && !cfg.redund) || redDone;
  assign wantNext = inPkt && lastUnit && (byteCnt != ts_out_pkg::PKT_LAST);
  assign needByte = wantFirst || wantNext;
  assign avail = srcValid && (wantNext || srcWord.first);
  assign stall = isLaunch && needByte && !avail;
  assign go = isLaunch && !stall;
  assign take = go && needByte;
  assign startPkt = take && wantFirst;
  assign nextByte = take && wantNext;
  assign shiftBit = go && inPkt && !lastUnit; // [R9]
  assign enterRed = go && pktDone && cfg.redund; // [R7]
  // a stray non-first byte is dropped while a packet start is awaited
  assign srcReady = take || (wantFirst && srcValid && !srcWord.first);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk <= 1'b0;
      halfCnt <= 8'h00;
    end else if (!cfg.enable) begin
      sclk <= 1'b0;
      halfCnt <= 8'h00;
    end else if (!stall) begin
      if (tick) begin
        sclk <= ~sclk;
        halfCnt <= 8'h00;
      end else begin
        halfCnt <= halfCnt + 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ts_out_pkg::ST_IDLE;
    end else if (!cfg.enable) begin
      state <= ts_out_pkg::ST_IDLE;
    end else if (startPkt) begin
      state <= ts_out_pkg::ST_PACKET;
    end else if (enterRed) begin
      state <= ts_out_pkg::ST_REDUND; // [R7]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      byteCnt <= 8'h00;
      bitIdx <= 3'h0;
      shiftReg <= 8'h00;
    end else if (startPkt) begin
      byteCnt <= 8'h00;
      bitIdx <= 3'h0;
      shiftReg <= srcWord.data;
    end else if (nextByte) begin
      byteCnt <= byteCnt + 8'h01; // [R3]
      bitIdx <= 3'h0;
      shiftReg <= srcWord.data; // [R8]
    end else if (shiftBit) begin
      bitIdx <= bitIdx + 3'h1;
      shiftReg <= {shiftReg[6:0], 1'b0}; // [R9]
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      redCnt <= 12'h000;
    end else if (enterRed) begin
      redCnt <= 12'h000;
    end else if (go && (state == ts_out_pkg::ST_REDUND) && !redDone) begin
      redCnt <= redCnt + 12'h001;
    end
  end

  // marker drops at the next byte load: one clock parallel, eight serial
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      markAct <= 1'b0;
      errAct <= 1'b0;
    end else if (startPkt) begin
      markAct <= 1'b1; // [R6] [R14]
      errAct <= srcWord.error; // [R5]
    end else if (nextByte) begin
      markAct <= 1'b0; // [R6] [R14]
    end else if (enterRed) begin
      markAct <= 1'b0;
      errAct <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pktCnt <= 16'h0000;
    end else if (go && pktDone) begin
      pktCnt <= pktCnt + 16'h0001;
    end
  end

  assign strobeAct = cfg.enable && (!cfg.redund || inPkt); // [R4] [R7]

  // one register stage keeps every pin aligned with the stream clock pin
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tsOut <= '0;
    end else begin
      tsOut.streamClockOut <= sclk ^ cfg.clkInv; // [R1]
      tsOut.firstByteMarker <= (inPkt && markAct) ^ cfg.markInv; // [R1]
      tsOut.payloadValidStrobe <= strobeAct ^ cfg.strobeInv; // [R1] [R4]
      tsOut.packetErrorFlag <= (inPkt && errAct) ^ cfg.errInv; // [R1] [R5]
      tsOut.serialStreamOut <= inPkt && cfg.serial && shiftReg[7]; // [R9]
      tsOut.parallelStreamBus <= (inPkt && !cfg.serial) ? shiftReg
                                                       : 8'h00; // [R8]
    end
  end

  // helpers read only by the checks below
  logic [8:0] seen;
  logic [3:0] markLen;
  logic markVis;
  assign markVis = inPkt && markAct;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      seen <= 9'h000;
    end else if (!cfg.enable) begin
      seen <= 9'h000;
    end else if (startPkt) begin
      seen <= 9'h001;
    end else if (nextByte) begin
      seen <= seen + 9'h001;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      markLen <= 4'h0;
    end else if (startPkt) begin
      markLen <= 4'h0;
    end else if (go && markVis && (markLen != 4'hF)) begin
      markLen <= markLen + 4'h1;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  chk_pkt_length: assert property ( // [R3]
    startPkt && (seen != 9'h000) |-> seen == 9'(ts_out_pkg::PKT_BYTES))
    else $error("packet length is not 188 bytes");

  chk_strobe_dataonly: assert property ( // [R4]
    (cfg.enable && !cfg.redund) ##1 $stable(cfg)
    |-> tsOut.payloadValidStrobe == !cfg.strobeInv)
    else $error("strobe dropped in data-only framing");

  chk_strobe_redund: assert property ( // [R7]
    (state == ts_out_pkg::ST_REDUND) ##1 $stable(cfg)
    |-> tsOut.payloadValidStrobe == cfg.strobeInv)
    else $error("strobe active during redundancy");

  // state and stream clock fall back one cycle after the disable lands
  chk_idle_polarity: assert property ( // [R1]
    !cfg.enable ##1 $stable(cfg) ##1 $stable(cfg)
    |-> (tsOut.packetErrorFlag == cfg.errInv) &&
        (tsOut.firstByteMarker == cfg.markInv) &&
        (tsOut.streamClockOut == cfg.clkInv))
    else $error("idle pin levels ignore polarity");

  chk_err_capture: assert property ( // [R5]
    startPkt |=> errAct == $past(srcWord.error))
    else $error("error flag not taken at packet start");

  chk_err_steady: assert property ( // [R5]
    inPkt && !startPkt && cfg.enable
    |=> $stable(errAct) || (state == ts_out_pkg::ST_REDUND))
    else $error("error flag changed inside a packet");

  chk_mark_serial: assert property ( // [R6]
    $fell(markVis) && cfg.enable && cfg.serial && $stable(cfg)
    |-> markLen == ts_out_pkg::MARK_SERIAL_LEN)
    else $error("serial marker not eight clocks");

  chk_mark_par: assert property ( // [R14]
    $fell(markVis) && cfg.enable && !cfg.serial && $stable(cfg)
    |-> markLen == ts_out_pkg::MARK_PAR_LEN)
    else $error("parallel marker not one clock");

  chk_launch_edge: assert property ( // [R2]
    go ##1 $stable(cfg) ##1 $stable(cfg)
    |-> tsOut.streamClockOut == cfg.launchRise)
    else $error("outputs launched on wrong clock edge");

  chk_par_byte: assert property ( // [R8]
    take && !cfg.serial
    |-> ##2 tsOut.parallelStreamBus == $past(srcWord.data, 2))
    else $error("parallel byte not on bus");

  chk_serial_msb: assert property ( // [R9]
    take && cfg.serial
    |-> ##2 tsOut.serialStreamOut == $past(srcWord.data[7], 2))
    else $error("serial bit not msb first");

  cov_serial_pkt: cover property (go && pktDone && cfg.serial);
  cov_par_redund: cover property (enterRed && !cfg.serial);
  cov_err_pkt: cover property (startPkt && srcWord.error);
  cov_stall: cover property (stall && inPkt);

endmodule : transport_stream_output_port

// *** rtl/ts_out_pkg.sv ***
// shared constants, register map and carrier types of the stream output port
// assumes a 32-bit APB slave with word-aligned registers
package ts_out_pkg;

  // register byte offsets
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DIV_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] PKTCNT_OFS = 12'h00C;

  // reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h07;

  // status field positions
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_STALL_BIT = 1;
  localparam int unsigned STAT_RED_BIT = 2;
  localparam int unsigned STAT_BYTE_LSB = 8;

  // packet framing
  localparam int unsigned PKT_BYTES = 188;
  localparam logic [7:0] PKT_LAST = 8'(PKT_BYTES - 1);
  localparam int unsigned BITS_PER_BYTE = 8;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] MARK_SERIAL_LEN = 4'h8;
  localparam logic [3:0] MARK_PAR_LEN = 4'h1;
  localparam int unsigned RED_BYTES_DEFAULT = 20;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PACKET = 2'b01,
    ST_REDUND = 2'b11
  } fmt_state_t;

  // control register layout, bit 0 is enable
  typedef struct packed {
    logic errInv;
    logic strobeInv;
    logic markInv;
    logic clkInv;
    logic launchRise;
    logic redund;
    logic serial;
    logic enable;
  } cfg_t;

  typedef struct packed {
    logic first;
    logic error;
    logic [7:0] data;
  } src_t;

  typedef struct packed {
    logic streamClockOut;
    logic firstByteMarker;
    logic payloadValidStrobe;
    logic packetErrorFlag;
    logic serialStreamOut;
    logic [7:0] parallelStreamBus;
  } pins_t;

endpackage : ts_out_pkg

// *** test/transport_stream_output_port_tb.sv ***
// self-checking bench: random packets in, receiver model judges the pins
// assumes zero-wait APB and a source that holds each word until taken
`timescale 1ns/1ps
module transport_stream_output_port_tb;
  localparam int RED = 2;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr;
  logic srcValid, srcReady, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] d, lastFirst, prevFirst, curFirst;
  logic [3:0] e, g;
  logic [1:0] lastErr;
  ts_out_pkg::src_t srcWord;
  ts_out_pkg::pins_t tsOut;
  ts_out_pkg::cfg_t cfg, c;
  int fails, checksDone, pktSeen, lastCount, lastMark, lastGap;
  int k = 0;
  int n, seen, u;

  transport_stream_output_port #(.RED_BYTES(RED)) u_dut (.mclk(mclk),
    .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .srcValid(srcValid), .srcWord(srcWord),
    .srcReady(srcReady), .tsOut(tsOut));
  ts_demux_model u_rx (.mclk(mclk), .nrst(nrst), .cfg(cfg), .pins(tsOut),
    .pktSeen(pktSeen), .lastCount(lastCount), .lastMark(lastMark),
    .lastGap(lastGap), .lastFirst(lastFirst), .lastErr(lastErr));

  // mclk stands for the core clock built from the 4 or 25 MHz reference
  always #2.5 mclk = ~mclk;

  // error bit follows data bit 0, so the first byte predicts the flag
  always @(posedge mclk) begin
    if (srcValid && srcReady) begin
      k = (k == 187) ? 0 : k + 1;
      // every taken first word opens a packet; keep the last two
      if (srcWord.first) begin
        prevFirst = curFirst;
        curFirst = srcWord.data;
      end
    end
    if (!srcValid || srcReady) begin
      d = 8'($urandom);
      srcValid <= $urandom_range(3) != 0;
      srcWord <= '{first: k == 0, error: d[0], data: d};
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] y);
    checksDone++;
    if (y !== x) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, y);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] wd);
    int w;
    @(posedge mclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (pready !== 1'b1 && w < 16);
    chk("apb ready", 1, 32'(w < 16));
    if (w >= 16)
      giveVerdict();
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", checksDone, fails);
    if (fails == 0 && checksDone > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : giveVerdict

  initial begin
    repeat (95000) @(posedge mclk);
    fails++;
    $display("CHECK FAILED run limit expected end seen running");
    giveVerdict();
  end

  initial begin
    void'($urandom(32'h0879919B));
    mclk = 0;
    nrst = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = '0;
    pwdata = '0;
    srcValid = 0;
    srcWord = '0;
    cfg = '0;
    // short hold stands in for the long power-up hold
    repeat (20) @(posedge mclk);
    chk("pins in reset", 0, 32'(tsOut));
    chk("ready in reset", 0, 32'(srcReady));
    nrst <= 1;
    repeat (3) @(posedge mclk);
    apb(0, ts_out_pkg::CTRL_OFS, 0);
    chk("CTRL reset", 32'(ts_out_pkg::CTRL_RESET), rd);
    apb(0, ts_out_pkg::DIV_OFS, 0);
    chk("DIV reset", 32'(ts_out_pkg::DIV_RESET), rd);
    apb(0, 12'h010, 0);
    chk("unmapped error", 1, 32'(er));
    chk("unmapped data", 0, rd);
    for (int m = 0; m < 8; m++) begin
      c = ts_out_pkg::cfg_t'($urandom);
      c.enable = 0;
      c.serial = m[0];
      c.redund = m[1];
      cfg <= c;
      apb(1, ts_out_pkg::CTRL_OFS, 32'(c));
      apb(1, ts_out_pkg::DIV_OFS, m[0] ? 0 : $urandom_range(2));
      c.enable = 1;
      apb(1, ts_out_pkg::CTRL_OFS, 32'(c));
      cfg <= c;
      seen = pktSeen;
      n = 0;
      while (pktSeen < seen + 2 && n < 30000) begin
        @(posedge mclk);
        n++;
      end
      u = m[0] ? 8 : 1;
      chk("packet wait", 1, 32'(n < 30000));
      if (n >= 30000)
        giveVerdict();
      chk("units per packet", 188 * u, lastCount);
      chk("marker units", u, lastMark);
      chk("strobe off units", m[1] ? RED * u : 0, lastGap);
      // the report covers the second packet of this mode
      chk("first byte", 32'(prevFirst), 32'(lastFirst));
      chk("error flag", {2{prevFirst[0]}}, lastErr);
      c.enable = 0;
      apb(1, ts_out_pkg::CTRL_OFS, 32'(c));
      cfg <= c;
      repeat (8) @(posedge mclk);
      e = {c.clkInv, c.markInv, c.strobeInv, c.errInv};
      g = {tsOut.streamClockOut, tsOut.firstByteMarker,
        tsOut.payloadValidStrobe, tsOut.packetErrorFlag};
      chk("rest levels", 32'(e), 32'(g));
    end
    apb(0, ts_out_pkg::PKTCNT_OFS, 0);
    seen = rd;
    // two whole packets per mode, the third is cut by the disable
    chk("packets counted", 32'(2 * 8), rd);
    apb(1, ts_out_pkg::PKTCNT_OFS, 32'h0000FFFF);
    apb(0, ts_out_pkg::PKTCNT_OFS, 0);
    chk("read-only count", 32'(seen), rd);
    giveVerdict();
  end
endmodule : transport_stream_output_port_tb

// *** test/ts_demux_model.sv ***
// far-side receiver model: takes one unit per stream clock, mid-unit
// assumes cfg mirrors the control register and changes only when disabled
`timescale 1ns/1ps
module ts_demux_model (
  input wire logic mclk,
  input wire logic nrst,
  input wire ts_out_pkg::cfg_t cfg,
  input wire ts_out_pkg::pins_t pins,
  output int pktSeen,
  output int lastCount,
  output int lastMark,
  output int lastGap,
  output logic [7:0] lastFirst,
  output logic [1:0] lastErr
);
  logic prevClk, prevMk, inPkt, errAll, errAny;
  logic [7:0] sh, first;
  int cnt, mark, gap;
  wire logic mk = pins.firstByteMarker ^ cfg.markInv;
  wire logic st = pins.payloadValidStrobe ^ cfg.strobeInv;
  wire logic er = pins.packetErrorFlag ^ cfg.errInv;
  wire logic bt = pins.serialStreamOut;
  // sample on the edge opposite to launch, where data is settled
  wire logic capt = pins.streamClockOut != prevClk &&
    pins.streamClockOut != cfg.launchRise;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pktSeen <= 0;
      inPkt <= 0;
      prevClk <= 0;
      prevMk <= 0;
    end else begin
      prevClk <= pins.streamClockOut;
      if (!cfg.enable) begin
        inPkt <= 0;
        prevMk <= 0;
      end else if (capt) begin
        prevMk <= mk;
        if (mk && st && !prevMk) begin
          // a packet is reported only once the next one starts
          if (inPkt) begin
            pktSeen <= pktSeen + 1;
            lastCount <= cnt;
            lastMark <= mark;
            lastGap <= gap;
            lastFirst <= first;
            lastErr <= {errAll, errAny};
          end
          inPkt <= 1;
          cnt <= 1;
          mark <= 1;
          gap <= 0;
          errAll <= er;
          errAny <= er;
          sh <= {7'h00, bt};
          first <= pins.parallelStreamBus;
        end else if (inPkt && st) begin
          cnt <= cnt + 1;
          mark <= mark + int'(mk);
          errAll <= errAll & er;
          errAny <= errAny | er;
          sh <= {sh[6:0], bt};
          if (cfg.serial && cnt == 7)
            first <= {sh[6:0], bt};
        end else if (inPkt)
          gap <= gap + 1;
      end
    end
  end
endmodule : ts_demux_model
